//--- design/lsp_policy.sv
// power-aware link speed policy top
`timescale 1ns/100ps
`default_nettype none
module lsp_policy (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic fully_active_state,
  input wire logic power_good_loss_state,
  input wire logic reduced_speed_linkup,
  input wire logic active_state_reduced_speed_enable,
  input wire logic gigabit_disable,
  input wire logic gigabit_disable_outside_active,
  input wire logic [2:0] sw_advertise,
  input wire logic smbus_manage_en,
  input wire logic magic_packet_wake,
  input wire logic pme_enable,
  input wire logic stop_linkup,
  input wire logic link_up,
  input wire logic link_at_gigabit,
  input wire logic [2:0] partner_speeds,
  input wire logic partner_no_autoneg,
  output logic [2:0] advertise,
  output logic autoneg_restart,
  output logic parallel_detect_en,
  output logic crossover_resolve_en,
  output logic phy_enable,
  output logic linkup_stage2
);
  lsp_pkg::lsp_state_e state_r;
  lsp_pkg::lsp_state_e state_nxt;
  logic act_r;
  logic pgl_r;
  logic gig_ok_r;
  logic lpl_on_r;
  logic first_r;
  logic [2:0] adv_nxt;
  logic [2:0] base_adv;
  logic [2:0] cap;
  logic gig_ok;
  logic lpl_on;
  logic keep_link;
  logic restart_nxt;
  logic try_start;
  logic expired;
  logic in_idle;
  logic in_first;
  logic in_adapt;
  logic enter_first;
  logic enter_adapt;
  logic retry_due;
  logic drop_gig;
  logic pgl_entry;
  logic state_flip;
  logic lpl_flip;
  logic gig_flip;

  // speeds from 10 up to the lowest one the partner supports
  function automatic logic [2:0] widen(input logic [2:0] p);
    if (p[0]) begin
      widen = lsp_pkg::lsp_adv_10;
    end else if (p[1]) begin
      widen = lsp_pkg::lsp_adv_10 | lsp_pkg::lsp_adv_100;
    end else begin
      widen = lsp_pkg::lsp_adv_all;
    end
  endfunction

  // state test shared by the decoders
  function automatic logic is_state(
    input lsp_pkg::lsp_state_e s,
    input lsp_pkg::lsp_state_e t
  );
    is_state = (s == t);
  endfunction

  // a try ends on link, on a stop command or when the feature is off
  function automatic logic try_done(
    input logic up,
    input logic stop,
    input logic on
  );
    try_done = up || stop || !on;
  endfunction

  lsp_try_timer lsp_try_timer_inst (
    .clock(clock),
    .rst_b(rst_b),
    .start(try_start),
    .expired(expired)
  );

  // gigabit permission per power state
  assign gig_ok = fully_active_state ? !gigabit_disable
                  : !(gigabit_disable || gigabit_disable_outside_active);

  assign cap = gig_ok ? lsp_pkg::lsp_adv_all
               : (lsp_pkg::lsp_adv_10 | lsp_pkg::lsp_adv_100);

  // active uses dedicated enable, others the nvm-loaded live bit
  assign lpl_on = fully_active_state ? active_state_reduced_speed_enable
                  : reduced_speed_linkup;

  // outside active, link only when a client needs it
  assign keep_link = fully_active_state || smbus_manage_en || magic_packet_wake
                     || pme_enable;

  // starting point: software value when active, 10 only otherwise
  assign base_adv = fully_active_state ? sw_advertise
                    : lsp_pkg::lsp_adv_10;

  assign in_idle = is_state(state_r, lsp_pkg::lsp_idle_st);
  assign in_first = is_state(state_r, lsp_pkg::lsp_first_st);
  assign in_adapt = is_state(state_r, lsp_pkg::lsp_adapt_st);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      act_r <= 1'b0;
    end else begin
      act_r <= fully_active_state;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pgl_r <= 1'b0;
    end else begin
      pgl_r <= power_good_loss_state;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      gig_ok_r <= 1'b0;
    end else begin
      gig_ok_r <= gig_ok;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      lpl_on_r <= 1'b0;
    end else begin
      lpl_on_r <= lpl_on;
    end
  end

  // only the first power-good-loss entry after power-up counts
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      first_r <= 1'b1;
    end else if (pgl_r) begin
      first_r <= 1'b0;
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      lsp_pkg::lsp_off_st: begin
        if (keep_link) begin
          state_nxt = lsp_pkg::lsp_idle_st;
        end
      end
      lsp_pkg::lsp_idle_st: begin
        if (!keep_link) begin
          state_nxt = lsp_pkg::lsp_off_st;
        end else if (lpl_on && !link_up && !stop_linkup) begin
          state_nxt = lsp_pkg::lsp_first_st;
        end
      end
      lsp_pkg::lsp_first_st: begin
        if (!keep_link) begin
          state_nxt = lsp_pkg::lsp_off_st;
        end else if (try_done(link_up, stop_linkup, lpl_on)) begin
          state_nxt = lsp_pkg::lsp_idle_st;
        end else if (expired) begin
          state_nxt = lsp_pkg::lsp_adapt_st;
        end
      end
      lsp_pkg::lsp_adapt_st: begin
        if (!keep_link) begin
          state_nxt = lsp_pkg::lsp_off_st;
        end else if (try_done(link_up, stop_linkup, lpl_on)) begin
          state_nxt = lsp_pkg::lsp_idle_st;
        end
      end
      default: begin
        state_nxt = lsp_pkg::lsp_off_st;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= lsp_pkg::lsp_off_st;
    end else begin
      state_r <= state_nxt;
    end
  end

  // a fresh try when a stage begins or an adapt try times out
  assign enter_first = is_state(state_nxt, lsp_pkg::lsp_first_st) && !in_first;
  assign enter_adapt = in_first && is_state(state_nxt, lsp_pkg::lsp_adapt_st);
  assign retry_due = in_adapt && expired;
  assign try_start = enter_first || enter_adapt || retry_due;

  always_comb begin
    adv_nxt = lsp_pkg::lsp_adv_rst;
    case (state_r)
      lsp_pkg::lsp_first_st: begin
        adv_nxt = lsp_pkg::lsp_adv_10;
      end
      lsp_pkg::lsp_adapt_st: begin
        adv_nxt = (base_adv | widen(partner_speeds)) & cap;
      end
      lsp_pkg::lsp_idle_st: begin
        adv_nxt = (lpl_on ? base_adv : sw_advertise) & cap;
      end
      default: begin
        adv_nxt = lsp_pkg::lsp_adv_rst;
      end
    endcase
  end

  // restart causes: permission or lpl change, state change with lpl, gigabit drop, first power-good-loss entry, a try
  assign gig_flip = (gig_ok != gig_ok_r);
  assign lpl_flip = (lpl_on != lpl_on_r);
  assign state_flip = (fully_active_state != act_r) && lpl_on;
  assign drop_gig = !fully_active_state && act_r && gigabit_disable_outside_active
                    && link_at_gigabit;
  assign pgl_entry = power_good_loss_state && !pgl_r && first_r;
  assign restart_nxt = gig_flip || lpl_flip || state_flip || drop_gig || pgl_entry
                       || try_start;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      advertise <= lsp_pkg::lsp_adv_rst;
    end else begin
      advertise <= adv_nxt;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      autoneg_restart <= 1'b0;
    end else begin
      autoneg_restart <= restart_nxt && keep_link;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      parallel_detect_en <= 1'b0;
    end else begin
      parallel_detect_en <= in_adapt && partner_no_autoneg;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      crossover_resolve_en <= 1'b0;
    end else begin
      crossover_resolve_en <= in_first || (in_idle && !lpl_on);
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      phy_enable <= 1'b0;
    end else begin
      phy_enable <= keep_link;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      linkup_stage2 <= 1'b0;
    end else begin
      linkup_stage2 <= in_adapt;
    end
  end

endmodule // lsp_policy
`default_nettype wire

//--- design/lsp_try_timer.sv
// attempt timer for one link-up try
`timescale 1ns/100ps
`default_nettype none
module lsp_try_timer (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic start,
  output logic expired
);
  logic [4:0] cnt_r;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 5'h0;
    end else if (start) begin
      cnt_r <= lsp_pkg::lsp_try_cyc;
    end else if (cnt_r != 5'h0) begin
      cnt_r <= cnt_r - 5'h1;
    end
  end
  assign expired = (cnt_r == 5'h1);
endmodule // lsp_try_timer
`default_nettype wire

//--- shared/lsp_pkg.sv
// constants and types for the link speed power policy block
// Function
// - lpl off, no gigabit limit: negotiate highest speed both ends advertise.
// - reduced-speed procedure first tries link at 10 Mb/s regardless of autoneg.
// - on first failure widen advertisement up to partner's lowest speed, retry.
// - keep retrying until link is up or told to stop.
// - in partner-adapting step also enable parallel detection when needed.
// - crossover resolution runs during the first autoneg stage.
// - active, lpl off: highest speed; gigabit_disable drops 1000; outside bit ignored.
// - active, lpl on: procedure from software advertisement; gigabit_disable drops 1000.
// - not active, lpl off: highest speed; either disable bit drops 1000.
// - not active, lpl on: procedure from 10 Mb/s; either disable bit drops 1000.
// - active-state enable bit turns on reduced-speed linkup in active state.
// - outside active, keep link only for smbus, magic packet or pme; else disable.
// - reduced-speed bit at power-up loss state entry: advertise 10 only, link up.
// - reduced-speed bit, any non-active entry: advertise 10 only, link up.
// - non-active and autoneg needed with bit set: advertise 10 only, link up.
// - reduced-speed bit preloaded from nvm; latest written value is used.
// - restart autoneg when gigabit allowed/prohibited changes with power state.
// - outside bit set at gigabit on non-active entry: drop 1000, renegotiate.
package lsp_pkg;
  localparam int unsigned lsp_adv_w = 3;
  localparam logic [2:0] lsp_adv_10 = 3'h1;
  localparam logic [2:0] lsp_adv_100 = 3'h2;
  localparam logic [2:0] lsp_adv_1000 = 3'h4;
  localparam logic [2:0] lsp_adv_all = 3'h7;
  localparam logic [2:0] lsp_adv_rst = 3'h0;
  localparam int unsigned lsp_try_ns = 2000;
  localparam int unsigned lsp_clk_ns = 100;
  localparam logic [4:0] lsp_try_cyc = 5'((lsp_try_ns + lsp_clk_ns - 1) / lsp_clk_ns);
  typedef enum logic [3:0] {
    lsp_off_st = 4'h1,
    lsp_idle_st = 4'h2,
    lsp_first_st = 4'h4,
    lsp_adapt_st = 4'h8
  } lsp_state_e;
endpackage

//--- test/lsp_partner.sv
// remote link partner model
`timescale 1ns/100ps
`default_nettype none
module lsp_partner (
  input wire logic clock,
  input wire logic [2:0] advertise,
  input wire logic autoneg_restart,
  input wire logic parallel_detect_en,
  input wire logic [2:0] partner_speeds,
  input wire logic partner_no_autoneg,
  input wire logic [7:0] partner_delay,
  output logic link_up,
  output logic link_at_gigabit
);
  int cnt = 0;
  initial link_up = 1'b0;
  initial link_at_gigabit = 1'b0;
  always @(posedge clock) begin
    if (autoneg_restart) begin
      link_up <= 1'b0;
      cnt <= partner_delay;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      link_up <= (cnt == 1) && |(advertise & partner_speeds)
        && (!partner_no_autoneg || parallel_detect_en);
      link_at_gigabit <= advertise[2] & partner_speeds[2];
    end
  end
endmodule // lsp_partner
`default_nettype wire

//--- test/lsp_policy_properties.sv
// checker for the link speed policy block
`timescale 1ns/100ps
`default_nettype none
module lsp_policy_chk (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic fully_active_state,
  input wire logic gigabit_disable,
  input wire logic gigabit_disable_outside_active,
  input wire logic smbus_manage_en,
  input wire logic magic_packet_wake,
  input wire logic pme_enable,
  input wire logic stop_linkup,
  input wire logic link_up,
  input wire logic reduced_speed_linkup,
  input wire logic [2:0] partner_speeds,
  input wire logic [2:0] advertise,
  input wire logic autoneg_restart,
  input wire logic parallel_detect_en,
  input wire logic crossover_resolve_en,
  input wire logic phy_enable,
  input wire logic linkup_stage2
);
  wire logic gig_ok = !gigabit_disable && (fully_active_state || !gigabit_disable_outside_active);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  AST_NO_GIG_A: assert property ((fully_active_state && gigabit_disable) [*3] |-> !advertise[2])
    else $error("gigabit advertised while disabled");
  AST_NO_GIG_O: assert property ((!fully_active_state && gigabit_disable_outside_active) [*3]
    |-> !advertise[2])
    else $error("gigabit advertised outside active state");
  AST_PHY_OFF: assert property ((!fully_active_state && !smbus_manage_en && !magic_packet_wake
    && !pme_enable) [*3] |-> !phy_enable)
    else $error("transceiver enabled with no client");
  AST_OUT10: assert property ((!fully_active_state && reduced_speed_linkup && phy_enable
    && !linkup_stage2 && !link_up && !stop_linkup) [*4] |-> advertise == 3'h1)
    else $error("first attempt not at 10 only");
  AST_WIDE: assert property ((linkup_stage2 && !gigabit_disable && !gigabit_disable_outside_active
    && partner_speeds == lsp_pkg::lsp_adv_1000) [*3] |-> advertise == lsp_pkg::lsp_adv_all)
    else $error("second step did not widen advertisement");
  AST_PD: assert property (parallel_detect_en |-> linkup_stage2)
    else $error("parallel detect outside second step");
  AST_XOVER: assert property (crossover_resolve_en |-> !linkup_stage2)
    else $error("crossover resolution in second step");
  AST_PULSE: assert property (autoneg_restart |=> !autoneg_restart)
    else $error("restart pulse longer than one cycle");
  AST_RETRY: assert property (linkup_stage2 && !link_up && !stop_linkup |-> ##[0:25]
    (autoneg_restart || link_up || stop_linkup || !linkup_stage2))
    else $error("no retry while link down");
  AST_GIG_SWAP: assert property ($changed(fully_active_state) && $changed(gig_ok)
    && smbus_manage_en |-> ##[1:4] autoneg_restart)
    else $error("no restart on gigabit permission change");
endmodule // lsp_policy_chk
`default_nettype wire

//--- test/lsp_policy_test.sv
// testbench for the link speed policy block
`timescale 1ns/100ps
`default_nettype none
module lsp_policy_test;
  logic clock, rst_b, fully_active_state, power_good_loss_state, reduced_speed_linkup;
  logic active_state_reduced_speed_enable, gigabit_disable, gigabit_disable_outside_active;
  logic smbus_manage_en, magic_packet_wake, pme_enable, stop_linkup, link_up, link_at_gigabit;
  logic partner_no_autoneg, autoneg_restart, parallel_detect_en, crossover_resolve_en;
  logic phy_enable, linkup_stage2;
  logic [2:0] sw_advertise, partner_speeds, advertise;
  logic [7:0] partner_delay;
  int mismatches = 0;
  int comparisons = 0;
  int n;
  lsp_policy lsp_policy_inst (.*);
  lsp_partner lsp_partner_inst (.*);
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task step(int k);
    repeat (k) @(posedge clock);
    #10;
  endtask
  task chk(logic [2:0] exp, logic [2:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task enter(logic l, logic go);
    fully_active_state = 1'b1;
    step(6);
    {fully_active_state, reduced_speed_linkup, gigabit_disable_outside_active} = {1'b0, l, go};
    step(5);
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #2000000;
    mismatches++;
    final_report;
  end
  initial begin
    {rst_b, fully_active_state, power_good_loss_state, reduced_speed_linkup} = 4'h0;
    {active_state_reduced_speed_enable, gigabit_disable, gigabit_disable_outside_active} = 3'h0;
    {magic_packet_wake, pme_enable, stop_linkup, partner_no_autoneg} = 4'h0;
    {smbus_manage_en, sw_advertise, partner_speeds, partner_delay} = {1'b1, 6'h3f, 8'h03};
    step(3);
    chk(3'h0, advertise);
    rst_b = 1'b1;
    for (int i = 0; i < 8; i++) begin
      {fully_active_state, gigabit_disable, gigabit_disable_outside_active} = 3'(i);
      step(5);
      chk((i[1] || (!i[2] && i[0])) ? 3'h3 : 3'h7, advertise);
    end
    {fully_active_state, gigabit_disable} = 2'h0;
    $display("speed table test done");
    for (int i = 0; i < 4; i++) begin
      {smbus_manage_en, magic_packet_wake, pme_enable} = (i == 0) ? 3'h0 : 3'(1 << (i - 1));
      step(5);
      chk({2'h0, i != 0}, {2'h0, phy_enable});
    end
    $display("client test done");
    partner_speeds = 3'h4;
    power_good_loss_state = 1'b1;
    enter(1'b1, 1'b0);
    chk(3'h1, advertise);
    for (int i = 0; i < 40 && !linkup_stage2; i++) step(1);
    step(3);
    chk(3'h7, advertise);
    for (int i = 0; i < 30 && !link_up; i++) step(1);
    chk(3'h1, {2'h0, link_up});
    power_good_loss_state = 1'b0;
    enter(1'b1, 1'b1);
    for (int i = 0; i < 40 && !linkup_stage2; i++) step(1);
    step(3);
    chk(3'h3, advertise);
    n = 0;
    repeat (60) begin
      step(1);
      n += autoneg_restart;
    end
    chk(3'h1, {2'h0, n >= 2});
    stop_linkup = 1'b1;
    step(3);
    n = 0;
    repeat (60) begin
      step(1);
      n += autoneg_restart;
    end
    chk(3'h0, 3'(n));
    stop_linkup = 1'b0;
    $display("reduced speed test done");
    {partner_no_autoneg, partner_speeds} = 4'h9;
    enter(1'b1, 1'b0);
    for (int i = 0; i < 40 && !parallel_detect_en; i++) step(1);
    chk(3'h1, {2'h0, linkup_stage2});
    partner_no_autoneg = 1'b0;
    {fully_active_state, active_state_reduced_speed_enable, gigabit_disable} = 3'h7;
    step(40);
    chk(3'h0, {2'h0, advertise[2]});
    {active_state_reduced_speed_enable, gigabit_disable, reduced_speed_linkup} = 3'h0;
    step(5);
    chk(3'h7, advertise);
    $display("active state test done");
    final_report;
  end
endmodule // lsp_policy_test
bind lsp_policy lsp_policy_chk lsp_policy_chk_inst (.*);
`default_nettype wire
